// ==== verilog/irq_ctrl_pkg.sv ====
// Purpose: shared constants for the interrupt and vector controller
// Assumes: 8-bit register port, 20 MHz mclk
// Notes:   offsets of flag, control and core registers chosen locally
package irq_ctrl_pkg;
    localparam int          NUM_SRC        = 13;
    localparam int          VEC_W          = 4;
    localparam logic [7:0]  OFF_EXT_MASK   = 8'h3B;
    localparam logic [7:0]  OFF_EXT_FLAG   = 8'h3A;
    localparam logic [7:0]  OFF_SENSE_CTRL = 8'h35;
    localparam logic [7:0]  OFF_GLOBAL     = 8'h3F;
    localparam logic [7:0]  RST_EXT_MASK   = 8'h00;
    localparam logic [7:0]  RST_SENSE_CTRL = 8'h00;
    localparam int          BIT_EXT_B      = 7;
    localparam int          BIT_EXT_A      = 6;
    localparam int          BIT_GIE        = 7;
    localparam logic [VEC_W-1:0] VEC_EXT_A = 4'h1;
    localparam logic [VEC_W-1:0] VEC_EXT_B = 4'h2;
    localparam real         CLK_PERIOD_NS  = 50.0;
    localparam real         RESP_TIME_NS   = 200.0;
    localparam int          RESP_CYCLES    = int'(RESP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [2:0]  RESP_CNT_INIT  = 3'(RESP_CYCLES - 1);
    // sense codes per pin
    localparam logic [1:0]  SENSE_LOW      = 2'h0;
    localparam logic [1:0]  SENSE_FALL     = 2'h2;
    localparam logic [1:0]  SENSE_RISE     = 2'h3;
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_PUSH  = 2'b01,
        ST_VEC   = 2'b11,
        ST_GUARD = 2'b10
    } vec_state_t;
endpackage

// ==== verilog/ext_pin_if.sv ====
// Purpose: bundle between pin sensing module and controller
// Assumes: one clock domain
// Notes:   one lane per external pin
`timescale 1ns/1ps
interface ext_pin_if;
    logic [1:0] sense_a;
    logic [1:0] sense_b;
    logic       edge_a;
    logic       edge_b;
    logic       level_a;
    logic       level_b;
    modport sense (input sense_a, sense_b, output edge_a, edge_b, level_a, level_b);
    modport ctrl  (output sense_a, sense_b, input edge_a, edge_b, level_a, level_b);
endinterface

// ==== verilog/ext_pin_sense.sv ====
// Purpose: synchronise two external pins and detect edges or low level
// Assumes: pins asynchronous to mclk
// Notes:   change counts once stages two and three agree
`timescale 1ns/1ps
module ext_pin_sense
    import irq_ctrl_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  arst_n,
    input  wire logic  pin_a,
    input  wire logic  pin_b,
    ext_pin_if.sense   pif
);
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] st_q;
    logic [1:0] st_d;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] sense [2];

    assign sense[0] = pif.sense_a;
    assign sense[1] = pif.sense_b;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
            s3_q <= 2'h3;
            st_q <= 2'h3;
        end
        else
        begin
            s1_q <= {pin_b, pin_a};
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= st_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            assign st_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : st_q[g];
            assign rise[g] = st_d[g] & ~st_q[g];
            assign fall[g] = ~st_d[g] & st_q[g];
        end
    endgenerate

    assign pif.edge_a  = (sense[0] == SENSE_RISE) ? rise[0] :
                         (sense[0] == SENSE_FALL) ? fall[0] : 1'b0;
    assign pif.edge_b  = (sense[1] == SENSE_RISE) ? rise[1] :
                         (sense[1] == SENSE_FALL) ? fall[1] : 1'b0;
    assign pif.level_a = (sense[0] == SENSE_LOW) & ~st_q[0];
    assign pif.level_b = (sense[1] == SENSE_LOW) & ~st_q[1];
endmodule

// ==== verilog/prio_pick.sv ====
// Purpose: pick lowest-numbered pending source
// Assumes: bit i of request is vector i+1
// Notes:   pure combinational
`timescale 1ns/1ps
module prio_pick
    import irq_ctrl_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] req,
    output logic                    any,
    output logic [VEC_W-1:0]        vec
);
    logic [NUM_SRC-1:0] low_only;
    assign low_only = req & (~req + NUM_SRC'(1));
    assign any      = |req;
    always_comb
    begin
        vec = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (low_only[i])
            begin
                vec = VEC_W'(i + 1);
            end
        end
    end
endmodule

// ==== verilog/ext_irq_and_vector_control.sv ====
// Purpose: global enable, pending flags, priority vectoring, two pins
// Assumes: core pulses vec_taken at vector fetch and return_from_irq_instr_exec on return
// Notes:   other peripherals keep their own flags and pass them in
// Contract
// - accepting an interrupt clears global enable.
// - return instruction sets global enable; software may set it too.
// - vectoring clears the serving source's pending flag.
// - writing one clears a flag; zero leaves it.
// - flag sets even while its enable is clear.
// - flags held while globally disabled, then served by priority.
// - level interrupt has no flag, requests only while active.
// - mask bit 7 with global enable enables pin b, vector 2.
// - mask bit 6 with global enable enables pin a, vector 1.
// - two sense bits per pin select rise, fall or level.
// - in level mode edge flag held clear, request still made.
// - pin activity requests even when pin is an output.
// - edge on b sets flag bit 7, on a bit 6.
// - flag, enable and global enable set: jump to vector.
// - edge flag cleared by handler entry or writing one.
// - bits 5..0 of mask and flag read zero, ignore writes.
// - vector no sooner than four cycles after flag sets.
// - after return one main instruction runs before next interrupt.
// - each pin triggers on falling, rising edge or low level.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module ext_irq_and_vector_control
    import irq_ctrl_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 pin_a,
    input  wire logic                 pin_b,
    input  wire logic [NUM_SRC-3:0]   periph_req,
    output logic      [NUM_SRC-3:0]   periph_ack,
    input  wire logic                 insn_done,
    input  wire logic                 return_from_irq_instr_exec,
    input  wire logic                 vec_taken,
    output logic                      irq_req,
    output logic      [VEC_W-1:0]     irq_vec,
    output logic                      gie
);
    ext_pin_if pif ();

    logic [7:0]         mask_q;
    logic [1:0]         flag_q;
    logic [1:0]         flag_d;
    logic [3:0]         sense_q;
    logic               gie_q;
    logic               gie_d;
    logic [7:0]         rdata_q;
    logic [7:0]         rdata_d;
    logic [2:0]         cnt_q;
    logic [VEC_W-1:0]   vec_q;
    logic               req_q;
    logic [NUM_SRC-3:0] ack_q;
    logic [NUM_SRC-3:0] ack_d;
    vec_state_t         st_q;
    vec_state_t         st_d;
    logic [NUM_SRC-1:0] pend;
    logic               any_pend;
    logic [VEC_W-1:0]   pick_vec;
    logic               wr_mask;
    logic               wr_flag;
    logic               wr_sense;
    logic               wr_gie;
    logic               take_a;
    logic               take_b;
    logic               accept;
    logic               en_a;
    logic               en_b;
    logic               req_a;
    logic               req_b;
    logic               ret_q;

    ext_pin_sense u_sense
    (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin_a  (pin_a),
        .pin_b  (pin_b),
        .pif    (pif)
    );

    assign pif.sense_a = sense_q[1:0];
    assign pif.sense_b = sense_q[3:2];

    assign wr_mask  = reg_wr & (reg_addr == OFF_EXT_MASK);
    assign wr_flag  = reg_wr & (reg_addr == OFF_EXT_FLAG);
    assign wr_sense = reg_wr & (reg_addr == OFF_SENSE_CTRL);
    assign wr_gie   = reg_wr & (reg_addr == OFF_GLOBAL);

    assign en_a = mask_q[BIT_EXT_A];
    assign en_b = mask_q[BIT_EXT_B];

    assign req_a = en_a & (flag_q[0] | pif.level_a);
    assign req_b = en_b & (flag_q[1] | pif.level_b);

    assign pend = {periph_req, req_b, req_a};

    prio_pick u_pick
    (
        .req (pend),
        .any (any_pend),
        .vec (pick_vec)
    );

    // global enable, nesting, not right after return
    assign accept = ((st_q == ST_IDLE) | (st_q == ST_GUARD)) & gie_q & any_pend &
                    ~ret_q & ~return_from_irq_instr_exec;
    assign take_a = vec_taken & (st_q == ST_VEC) & (vec_q == VEC_EXT_A);
    assign take_b = vec_taken & (st_q == ST_VEC) & (vec_q == VEC_EXT_B);

    // set wins over clear; clear on vector
    assign flag_d[0] = (sense_q[1:0] == SENSE_LOW) ? 1'b0 :
                       pif.edge_a | (flag_q[0] & ~take_a &
                       ~(wr_flag & reg_wdata[BIT_EXT_A]));
    assign flag_d[1] = (sense_q[3:2] == SENSE_LOW) ? 1'b0 :
                       pif.edge_b | (flag_q[1] & ~take_b &
                       ~(wr_flag & reg_wdata[BIT_EXT_B]));

    // clear on accept; set on return; a write loads bit 7
    assign gie_d = accept ? 1'b0 :
                   return_from_irq_instr_exec ? 1'b1 :
                   wr_gie ? reg_wdata[BIT_GIE] : gie_q;

    // peripheral flag clear strobe at vector
    genvar g;
    generate
        for (g = 0; g < NUM_SRC - 2; g++)
        begin : g_ack
            assign ack_d[g] = vec_taken & (st_q == ST_VEC) & (vec_q == VEC_W'(g + 3));
        end
    endgenerate

    assign rdata_d = !reg_rd ? 8'h00 :
                     (reg_addr == OFF_EXT_MASK)   ? {mask_q[7:6], 6'h00} :
                     (reg_addr == OFF_EXT_FLAG)   ? {flag_q[1], flag_q[0], 6'h00} :
                     (reg_addr == OFF_SENSE_CTRL) ? {4'h0, sense_q} :
                     (reg_addr == OFF_GLOBAL)     ? {gie_q, 7'h00} : 8'h00;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:
            begin
                if (accept)
                begin
                    st_d = ST_PUSH;
                end
            end
            ST_PUSH:
            begin
                if (cnt_q == 3'h0)
                begin
                    st_d = ST_VEC;
                end
            end
            ST_VEC:
            begin
                if (vec_taken)
                begin
                    st_d = ST_GUARD;
                end
            end
            ST_GUARD:
            begin
                if (accept)
                begin
                    st_d = ST_PUSH;
                end
                else if (insn_done & ~return_from_irq_instr_exec)
                begin
                    st_d = ST_IDLE;
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_q  <= RST_EXT_MASK;
            sense_q <= RST_SENSE_CTRL[3:0];
            flag_q  <= 2'h0;
            gie_q   <= 1'b0;
            rdata_q <= 8'h00;
            ack_q   <= '0;
        end
        else
        begin
            if (wr_mask)
            begin
                mask_q <= {reg_wdata[7:6], 6'h00};
            end
            if (wr_sense)
            begin
                sense_q <= reg_wdata[3:0];
            end
            flag_q  <= flag_d;
            gie_q   <= gie_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q  <= ST_IDLE;
            cnt_q <= 3'h0;
            vec_q <= '0;
            req_q <= 1'b0;
            ret_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= accept ? RESP_CNT_INIT : (cnt_q != 3'h0 ? cnt_q - 3'h1 : cnt_q);
            if (accept)
            begin
                vec_q <= pick_vec;
            end
            req_q <= (st_d == ST_VEC);
            // return seen, no main instruction yet
            ret_q <= return_from_irq_instr_exec ? 1'b1 : (insn_done ? 1'b0 : ret_q);
        end
    end

    assign reg_rdata  = rdata_q;
    assign irq_req    = req_q;
    assign irq_vec    = vec_q;
    assign gie        = gie_q;
    assign periph_ack = ack_q;

    AST_GIE_CLR: assert property (@(posedge mclk) disable iff (!arst_n)
        accept |=> !gie_q)
        else $error("global enable not cleared on accept");

    AST_RETURN_FROM_IRQ_INSTR_SET: assert property (@(posedge mclk) disable iff (!arst_n)
        (return_from_irq_instr_exec && !accept) |=> gie_q)
        else $error("return did not set global enable");

    AST_RESP_MIN: assert property (@(posedge mclk) disable iff (!arst_n)
        accept |=> !irq_req [*3])
        else $error("vector requested too early");

    AST_RESP_MAX: assert property (@(posedge mclk) disable iff (!arst_n)
        accept |-> ##[1:5] irq_req)
        else $error("vector request late");

    // handler entry clears pin a flag
    AST_FLAG_A_CLR: assert property (@(posedge mclk) disable iff (!arst_n)
        (take_a && !pif.edge_a) |=> !flag_q[0])
        else $error("pin a flag kept after vectoring");

    AST_W1C: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr_flag && reg_wdata[BIT_EXT_B] && !pif.edge_b) |=> !flag_q[1])
        else $error("write one did not clear pin b flag");

    // edge sets flag regardless of enable
    AST_EDGE_SET: assert property (@(posedge mclk) disable iff (!arst_n)
        pif.edge_a |=> flag_q[0])
        else $error("edge did not set flag");

    AST_LEVEL_NOFLAG: assert property (@(posedge mclk) disable iff (!arst_n)
        (sense_q[3:2] == SENSE_LOW) |=> !flag_q[1])
        else $error("flag set in level mode");

    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
        $past(reg_rd) && ($past(reg_addr) == OFF_EXT_MASK) |-> reg_rdata[5:0] == 6'h00)
        else $error("reserved bits nonzero");

    AST_ONE_INSN: assert property (@(posedge mclk) disable iff (!arst_n)
        return_from_irq_instr_exec |=> !accept)
        else $error("served before one main instruction");
endmodule

// ==== test/cpu_core_model.sv ====
// Purpose: behavioural core fetching vectors and returning
// Assumes: single mclk domain
// Notes:   slow adds fetch wait states
`timescale 1ns/1ps
module cpu_core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic irq_req,
    input  wire logic slow,
    output logic      vec_taken,
    output logic      return_from_irq_instr_exec,
    output logic      insn_done
);
    initial
    begin
        vec_taken = 1'b0;
        return_from_irq_instr_exec = 1'b0;
        insn_done = 1'b0;
    end
    always
    begin
        @(posedge mclk);
        if (arst_n && irq_req === 1'b1)
        begin
            repeat (slow ? 3 : 0) @(posedge mclk);
            vec_taken <= 1'b1;
            @(posedge mclk);
            vec_taken <= 1'b0;
            repeat (6) @(posedge mclk);
            return_from_irq_instr_exec <= 1'b1;
            @(posedge mclk);
            return_from_irq_instr_exec <= 1'b0;
            insn_done <= 1'b1;
            @(posedge mclk);
            insn_done <= 1'b0;
        end
    end
endmodule

// ==== test/ext_irq_and_vector_control_bench.sv ====
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model answers vectors, bench plays peripherals
// Notes:   random peripheral requests from a fixed lfsr
`timescale 1ns/1ps
module ext_irq_and_vector_control_bench
    import irq_ctrl_pkg::*;
;
    logic               mclk = 1'b0;
    logic               arst_n = 1'b0;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         reg_rdata;
    logic               pin_a = 1'b1;
    logic               pin_b = 1'b1;
    logic [NUM_SRC-3:0] periph_req = '0;
    logic [NUM_SRC-3:0] periph_ack;
    logic [NUM_SRC-3:0] preq;
    logic               insn_done;
    logic               return_from_irq_instr_exec;
    logic               vec_taken;
    logic               irq_req;
    logic [VEC_W-1:0]   irq_vec;
    logic               gie;
    logic               slow = 1'b0;
    logic               ret_pend = 1'b0;
    logic               gie_prev = 1'b0;
    logic               ret_was = 1'b0;
    logic [31:0]        seed = 32'h49E0E49F;
    logic [7:0]         fb;
    logic [7:0]         rst_addr [5] = '{8'h3B, 8'h3A, 8'h35, 8'h3F, 8'h10};
    logic [VEC_W-1:0]   vq [$];
    logic [VEC_W-1:0]   eq [$];
    logic               gq [$];
    int                 num_errors = 0;
    int                 checks = 0;
    int                 n;

    always #25 mclk = ~mclk;

    ext_irq_and_vector_control i_ext_irq_and_vector_control (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_a(pin_a),
        .pin_b(pin_b), .periph_req(periph_req), .periph_ack(periph_ack),
        .insn_done(insn_done), .return_from_irq_instr_exec(return_from_irq_instr_exec), .vec_taken(vec_taken),
        .irq_req(irq_req), .irq_vec(irq_vec), .gie(gie));

    cpu_core_model i_cpu_core_model (
        .mclk(mclk), .arst_n(arst_n), .irq_req(irq_req), .slow(slow),
        .vec_taken(vec_taken), .return_from_irq_instr_exec(return_from_irq_instr_exec), .insn_done(insn_done));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask

    task automatic set_pin(input int p, input logic v);
        @(posedge mclk);
        if (p == 1)
            pin_b <= v;
        else
            pin_a <= v;
        tick(8);
    endtask

    task automatic wait_vecs(input int k);
        int w;
        w = 0;
        while (vq.size() < k && w < 3000)
        begin
            @(posedge mclk);
            w++;
        end
        if (vq.size() < k)
        begin
            chk("vector count", 8'(k), 8'(vq.size()));
            conclude();
        end
    endtask

    // peripheral flag logic drops a request on its ack
    always @(posedge mclk)
    begin
        if (|periph_ack)
            periph_req <= periph_req & ~periph_ack;
        if (vec_taken === 1'b1)
        begin
            vq.push_back(irq_vec);
            gq.push_back(gie);
        end
        if (gie === 1'b0 && gie_prev === 1'b1 && ret_was)
            chk("return guard", 8'h00, 8'h01);
        gie_prev <= gie;
        ret_was <= ret_pend;
        ret_pend <= return_from_irq_instr_exec ? 1'b1 : (insn_done ? 1'b0 : ret_pend);
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (rst_addr[i])
            rdchk("reset value", rst_addr[i], 8'h00);
        wr(OFF_EXT_MASK, 8'hFF);
        rdchk("mask reserved", OFF_EXT_MASK, 8'hC0);
        wr(OFF_EXT_MASK, 8'h00);
        // every sense code on both pins, enables clear
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 4; c++)
            begin
                fb = (p == 1) ? 8'h80 : 8'h40;
                wr(OFF_SENSE_CTRL, 8'(c << (2 * p)));
                set_pin(p, 1'b0);
                rdchk("fall flag", OFF_EXT_FLAG, (c == 2) ? fb : 8'h00);
                wr(OFF_EXT_FLAG, 8'h3F);
                rdchk("zero write", OFF_EXT_FLAG, (c == 2) ? fb : 8'h00);
                wr(OFF_EXT_FLAG, 8'hC0);
                rdchk("one write", OFF_EXT_FLAG, 8'h00);
                set_pin(p, 1'b1);
                rdchk("rise flag", OFF_EXT_FLAG, (c == 3) ? fb : 8'h00);
                wr(OFF_EXT_FLAG, 8'hC0);
            end
        // pending while globally off, then served in order
        repeat (2)
        begin
            seed = lfsr(seed);
            slow <= seed[31];
            vq.delete();
            gq.delete();
            wr(OFF_SENSE_CTRL, 8'h0A);
            wr(OFF_EXT_MASK, 8'hC0);
            set_pin(0, 1'b0);
            set_pin(1, 1'b0);
            preq = {1'b1, seed[NUM_SRC-4:0]};
            @(posedge mclk);
            periph_req <= preq;
            tick(20);
            chk("held request", 8'h00, {7'h00, irq_req});
            rdchk("both flags", OFF_EXT_FLAG, 8'hC0);
            wr(OFF_GLOBAL, 8'h80);
            n = 0;
            while (irq_req !== 1'b1 && n < 50)
            begin
                tick(1);
                n++;
            end
            chk("response", 8'h01, {7'h00, n >= 4 && n < 50});
            eq = {VEC_EXT_A, VEC_EXT_B};
            for (int i = 0; i < NUM_SRC - 2; i++)
                if (preq[i])
                    eq.push_back(4'(i + 3));
            wait_vecs(eq.size());
            foreach (eq[i])
            begin
                chk("vector order", {4'h0, eq[i]}, {4'h0, vq[i]});
                chk("gie at vector", 8'h00, {7'h00, gq[i]});
            end
            tick(12);
            chk("gie after return", 8'h01, {7'h00, gie});
            rdchk("flags cleared", OFF_EXT_FLAG, 8'h00);
            chk("peripheral acks", 8'h00, {7'h00, |periph_req});
            wr(OFF_GLOBAL, 8'h00);
            set_pin(0, 1'b1);
            set_pin(1, 1'b1);
        end
        // level request follows the pin and keeps no flag
        vq.delete();
        wr(OFF_SENSE_CTRL, 8'h08);
        wr(OFF_EXT_MASK, 8'h40);
        wr(OFF_GLOBAL, 8'h80);
        set_pin(0, 1'b0);
        wait_vecs(1);
        chk("level vector", {4'h0, VEC_EXT_A}, {4'h0, vq[0]});
        rdchk("level flag", OFF_EXT_FLAG, 8'h00);
        set_pin(0, 1'b1);
        tick(60);
        n = vq.size();
        tick(40);
        chk("level released", 8'(n), 8'(vq.size()));
        conclude();
    end
endmodule
